// File: src/rtc_defines.svh
// Purpose: constants of the rtc timer, alarm and clock monitor core
// Assumes: 200 MHz system clock
// Notes:   counts from nominal times, rounded up
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
`define RTC_CLK_PERIOD_NS   5
`define RTC_MCD_TIMEOUT_US  100
`define RTC_BLANK_MS        2
`define RTC_MCD_TIMEOUT_CYC ((`RTC_MCD_TIMEOUT_US*1000+`RTC_CLK_PERIOD_NS-1)/`RTC_CLK_PERIOD_NS)
`define RTC_BLANK_CYC       ((`RTC_BLANK_MS*1000000+`RTC_CLK_PERIOD_NS-1)/`RTC_CLK_PERIOD_NS)
`define RTC_TIMER_W         32
`define RTC_CNT_W           20
`define RTC_BYTES           4
`define RTC_BYTE_W          8
`define RTC_TIMER_ZERO      32'h0000_0000
`define RTC_TIMER_ONE       32'h0000_0001
`define RTC_CNT_ZERO        20'h0_0000
`define RTC_CNT_ONE         20'h0_0001
`endif

// File: src/rtc_pkg.sv
// Purpose: state type of the rtc core
// Assumes: rtc_defines.svh on the include path
// Notes:   whole core state lives in one packed struct
package rtc_pkg;
  `include "rtc_defines.svh"

  typedef struct packed {
    logic                    osc_s1;
    logic                    osc_s2;
    logic                    osc_prev;
    logic [`RTC_TIMER_W-1:0] timer;
    logic [`RTC_TIMER_W-1:0] capture;
    logic [`RTC_TIMER_W-1:0] alarm_match;
    logic                    auto_reset;
    logic                    load_req;
    logic                    snap_req;
    logic                    alarm_flag;
    logic                    clear_pending;
    logic                    osc_fail;
    logic                    crystal_valid;
    logic [`RTC_CNT_W-1:0]   mcd_cnt;
    logic [`RTC_CNT_W-1:0]   blank_cnt;
    logic                    irq_req;
    logic                    wake_req;
    logic                    rst_req;
  } rtc_state_type;
endpackage

// File: src/rtc_core.sv
// Purpose: rtc timer, equality alarm, load and snapshot handshakes,
//          missing-clock monitor and crystal-valid blanking
// Assumes: oscillator level asynchronous, all controls synchronous inputs
// Notes:   oscillator edges become one-cycle enables after a
//          two-flop synchroniser
`timescale 1ns/1ps
`include "rtc_defines.svh"

module rtc_core
  import rtc_pkg::*;
#(
  parameter int unsigned MCD_TIMEOUT_CYC = `RTC_MCD_TIMEOUT_CYC,
  parameter int unsigned BLANK_CYC       = `RTC_BLANK_CYC
) (
  input  wire logic                    SYS_CLK_IN,      // system clock
  input  wire logic                    RST_IN,          // sync reset
  input  wire logic                    OSC_IN,          // osc level
  input  wire logic                    OSC_ENABLE_IN,   // osc powered
  input  wire logic                    CRYSTAL_AMP_IN,  // amp detector
  input  wire logic                    MCD_ENABLE_IN,   // monitor on
  input  wire logic                    OSC_FAIL_CLR_IN, // clear fail
  input  wire logic                    TIMER_RUN_IN,    // run control
  input  wire logic                    ALARM_EN_IN,     // alarm enable
  input  wire logic                    AUTO_RST_WR_IN,  // flag bit write
  input  wire logic                    AUTO_RST_DATA_IN, // written value
  input  wire logic                    CAPTURE_WR_IN,   // capture write
  input  wire logic [`RTC_BYTES-1:0]   CAPTURE_BE_IN,   // byte enables
  input  wire logic [`RTC_TIMER_W-1:0] CAPTURE_DATA_IN, // capture data
  input  wire logic                    ALARM_WR_IN,     // match write
  input  wire logic [`RTC_BYTES-1:0]   ALARM_BE_IN,     // byte enables
  input  wire logic [`RTC_TIMER_W-1:0] ALARM_DATA_IN,   // match data
  input  wire logic                    LOAD_REQ_IN,     // load pulse
  input  wire logic                    SNAP_REQ_IN,     // snapshot pulse
  input  wire logic                    ALARM_IRQ_EN_IN, // alarm to irq
  input  wire logic                    ALARM_WAKE_EN_IN, // alarm wake
  input  wire logic                    ALARM_RST_EN_IN, // alarm reset
  input  wire logic                    MCD_IRQ_EN_IN,   // fail to irq
  input  wire logic                    MCD_WAKE_EN_IN,  // fail wake
  input  wire logic                    MCD_RST_EN_IN,   // fail reset
  output logic [`RTC_TIMER_W-1:0]      TIMER_OUT,       // timer count
  output logic [`RTC_TIMER_W-1:0]      CAPTURE_OUT,     // capture regs
  output logic [`RTC_TIMER_W-1:0]      ALARM_MATCH_OUT, // match regs
  output logic                         LOAD_BUSY_OUT,   // load pending
  output logic                         SNAP_BUSY_OUT,   // snap pending
  output logic                         AUTO_RST_OUT,    // auto-reset on
  output logic                         ALARM_FLAG_OUT,  // alarm flag
  output logic                         OSC_FAIL_OUT,    // fail flag
  output logic                         CRYSTAL_VALID_OUT, // valid status
  output logic                         IRQ_REQ_OUT,     // irq pulse
  output logic                         WAKE_REQ_OUT,    // wake pulse
  output logic                         RESET_REQ_OUT    // reset pulse
);

  localparam logic [`RTC_CNT_W-1:0] MCD_LIMIT =
    `RTC_CNT_W'(MCD_TIMEOUT_CYC);
  localparam logic [`RTC_CNT_W-1:0] BLANK_LIMIT =
    `RTC_CNT_W'(BLANK_CYC);

  rtc_state_type                     state_reg;
  rtc_state_type                     state_next;
  logic [`RTC_TIMER_W-1:0]           cap_merged;
  logic [`RTC_TIMER_W-1:0]           match_merged;
  logic                              tick;
  logic                              osc_edge;
  logic                              timer_moves;
  logic [`RTC_TIMER_W-1:0]           timer_new;
  logic                              alarm_evt;
  logic                              mcd_evt;

  // ********************************************************
  // byte-wise merge of capture and match writes
  // ********************************************************
  generate
    for (genvar i = 0; i < `RTC_BYTES; i++) begin : g_byte
      assign cap_merged[`RTC_BYTE_W*i +: `RTC_BYTE_W] =
        (CAPTURE_WR_IN && CAPTURE_BE_IN[i]) ?
        CAPTURE_DATA_IN[`RTC_BYTE_W*i +: `RTC_BYTE_W] :
        state_reg.capture[`RTC_BYTE_W*i +: `RTC_BYTE_W];
      assign match_merged[`RTC_BYTE_W*i +: `RTC_BYTE_W] =
        (ALARM_WR_IN && ALARM_BE_IN[i]) ?
        ALARM_DATA_IN[`RTC_BYTE_W*i +: `RTC_BYTE_W] :
        state_reg.alarm_match[`RTC_BYTE_W*i +: `RTC_BYTE_W];
    end
  endgenerate

  // ********************************************************
  // oscillator edge enables
  // ********************************************************
  assign tick     = state_reg.osc_s2 && !state_reg.osc_prev;
  assign osc_edge = state_reg.osc_s2 != state_reg.osc_prev;

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    state_next        = state_reg;
    state_next.osc_s1 = OSC_IN;
    state_next.osc_s2 = state_reg.osc_s1;
    state_next.osc_prev = state_reg.osc_s2;

    // timer update on oscillator edge
    timer_moves = tick && (state_reg.clear_pending ||
                  state_reg.load_req || TIMER_RUN_IN);
    timer_new   = state_reg.timer;
    if (tick) begin
      if (state_reg.clear_pending) begin
        timer_new = `RTC_TIMER_ZERO;
      end else if (state_reg.load_req) begin
        timer_new = state_reg.capture;
      end else if (TIMER_RUN_IN) begin
        timer_new = state_reg.timer + `RTC_TIMER_ONE;
      end
    end
    state_next.timer = timer_new;

    // capture holding registers and handshakes
    state_next.capture = cap_merged;
    if (tick && state_reg.snap_req) begin
      state_next.capture = state_reg.timer;
    end
    if (tick) begin
      state_next.load_req = 1'b0;
      state_next.snap_req = 1'b0;
    end
    if (LOAD_REQ_IN) begin
      state_next.load_req = 1'b1;
    end
    if (SNAP_REQ_IN) begin
      state_next.snap_req = 1'b1;
    end

    // alarm compare and flag
    state_next.alarm_match = match_merged;
    if (AUTO_RST_WR_IN) begin
      state_next.auto_reset = AUTO_RST_DATA_IN;
    end
    alarm_evt = ALARM_EN_IN && timer_moves &&
                (timer_new == state_reg.alarm_match);
    if (!ALARM_EN_IN) begin
      state_next.alarm_flag = 1'b0;
    end else if (tick) begin
      state_next.alarm_flag = alarm_evt;
    end
    if (tick) begin
      state_next.clear_pending = alarm_evt && state_reg.auto_reset;
    end

    // missing-clock one-shot, retriggered by any level change
    mcd_evt = 1'b0;
    if (!MCD_ENABLE_IN || osc_edge) begin
      state_next.mcd_cnt = `RTC_CNT_ZERO;
    end else if (state_reg.mcd_cnt != MCD_LIMIT) begin
      state_next.mcd_cnt = state_reg.mcd_cnt + `RTC_CNT_ONE;
      mcd_evt = (state_reg.mcd_cnt + `RTC_CNT_ONE) == MCD_LIMIT;
    end
    if (OSC_FAIL_CLR_IN) begin
      state_next.osc_fail = 1'b0;
    end
    if (mcd_evt) begin
      state_next.osc_fail = 1'b1;
    end

    // crystal-valid blanking after oscillator turn-on
    if (!OSC_ENABLE_IN) begin
      state_next.blank_cnt = `RTC_CNT_ZERO;
    end else if (state_reg.blank_cnt != BLANK_LIMIT) begin
      state_next.blank_cnt = state_reg.blank_cnt + `RTC_CNT_ONE;
    end
    state_next.crystal_valid = CRYSTAL_AMP_IN && OSC_ENABLE_IN &&
      (state_reg.blank_cnt == BLANK_LIMIT);

    // gated request pulses toward system logic
    state_next.irq_req  = (alarm_evt && ALARM_IRQ_EN_IN) ||
                          (mcd_evt && MCD_IRQ_EN_IN);
    state_next.wake_req = (alarm_evt && ALARM_WAKE_EN_IN) ||
                          (mcd_evt && MCD_WAKE_EN_IN);
    state_next.rst_req  = (alarm_evt && ALARM_RST_EN_IN) ||
                          (mcd_evt && MCD_RST_EN_IN);
  end

  // ********************************************************
  // state register
  // ********************************************************
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign TIMER_OUT         = state_reg.timer;
  assign CAPTURE_OUT       = state_reg.capture;
  assign ALARM_MATCH_OUT   = state_reg.alarm_match;
  assign LOAD_BUSY_OUT     = state_reg.load_req;
  assign SNAP_BUSY_OUT     = state_reg.snap_req;
  assign AUTO_RST_OUT      = state_reg.auto_reset;
  assign ALARM_FLAG_OUT    = state_reg.alarm_flag;
  assign OSC_FAIL_OUT      = state_reg.osc_fail;
  assign CRYSTAL_VALID_OUT = state_reg.crystal_valid;
  assign IRQ_REQ_OUT       = state_reg.irq_req;
  assign WAKE_REQ_OUT      = state_reg.wake_req;
  assign RESET_REQ_OUT     = state_reg.rst_req;

  // ********************************************************
  // checks
  // ********************************************************
  a_timer_counts: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    tick && TIMER_RUN_IN && !state_reg.clear_pending &&
    !state_reg.load_req |=>
    state_reg.timer == $past(state_reg.timer) + `RTC_TIMER_ONE)
    else $error("timer did not advance on oscillator edge");

  a_timer_holds: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    !TIMER_RUN_IN && !state_reg.clear_pending && !state_reg.load_req
    |=> $stable(state_reg.timer))
    else $error("stopped timer changed");

  a_auto_reset_arm: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    tick && alarm_evt && state_reg.auto_reset |=>
    state_reg.clear_pending)
    else $error("auto-reset not armed by the alarm");

  a_auto_reset_clear: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    tick && state_reg.clear_pending |=>
    state_reg.timer == `RTC_TIMER_ZERO)
    else $error("auto-reset did not clear the timer");

  a_alarm_enable_clr: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    !ALARM_EN_IN |=> !state_reg.alarm_flag)
    else $error("alarm flag survived disable");

  a_alarm_on_match: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    $rose(state_reg.alarm_flag) |->
    state_reg.timer == state_reg.alarm_match)
    else $error("alarm without timer match");

  a_alarm_one_cycle: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    state_reg.alarm_flag && tick && !state_reg.clear_pending &&
    !state_reg.load_req |=> !state_reg.alarm_flag)
    else $error("alarm flag held past one oscillator cycle");

  a_load_transfer: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    tick && state_reg.load_req && !state_reg.clear_pending &&
    !LOAD_REQ_IN |=> !state_reg.load_req &&
    state_reg.timer == $past(state_reg.capture))
    else $error("load did not transfer capture to timer");

  a_snap_transfer: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    tick && state_reg.snap_req && !SNAP_REQ_IN |=>
    !state_reg.snap_req && state_reg.capture == $past(state_reg.timer))
    else $error("snapshot did not copy the timer");

  a_fail_needs_en: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    $rose(state_reg.osc_fail) |-> $past(MCD_ENABLE_IN) &&
    $past(state_reg.mcd_cnt) == MCD_LIMIT - `RTC_CNT_ONE)
    else $error("fail flag set without a full timeout");

  a_fail_sticky: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    state_reg.osc_fail && !OSC_FAIL_CLR_IN |=> state_reg.osc_fail)
    else $error("fail flag dropped without a clear");

  a_blank_valid: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    state_reg.blank_cnt != BLANK_LIMIT |=> !CRYSTAL_VALID_OUT)
    else $error("crystal valid shown during blanking");

  a_irq_gated: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    IRQ_REQ_OUT |-> $past(ALARM_IRQ_EN_IN || MCD_IRQ_EN_IN) ##1
    !IRQ_REQ_OUT)
    else $error("interrupt request not a gated pulse");

endmodule // rtc_core

// File: tb/rtc_core_test.sv
// Purpose: self-checking bench for the rtc timer, alarm and clock monitor
// Assumes: 200 MHz clock, bench oscillator of 8 system cycles a period
// Notes:   short monitor and blanking counts via parameters
`timescale 1ns/1ps

module rtc_core_test;
  import rtc_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam int unsigned MCD_CYC = 20;
  localparam int unsigned BLK_CYC = 16;
  logic        sys_clk, rst, osc, osc_en, amp, mcd_en, fail_clr, run;
  logic        alarm_en, ar_wr, ar_data, cap_wr, alm_wr, load_req, snap_req;
  logic        a_irq, a_wake, a_rst, m_irq, m_wake, m_rst, osc_on;
  logic [3:0]  cap_be, alm_be;
  logic [31:0] cap_data, alm_data, timer, capture, match, v;
  logic        load_busy, snap_busy, auto_rst, flag, fail, valid;
  logic        irq, wake, rreq;
  int          n_fail, comparisons, cnt, n_irq, n_wake, n_rst;

  rtc_core #(.MCD_TIMEOUT_CYC(MCD_CYC), .BLANK_CYC(BLK_CYC)) rtc_core_inst (
    .SYS_CLK_IN(sys_clk), .RST_IN(rst), .OSC_IN(osc),
    .OSC_ENABLE_IN(osc_en), .CRYSTAL_AMP_IN(amp), .MCD_ENABLE_IN(mcd_en),
    .OSC_FAIL_CLR_IN(fail_clr), .TIMER_RUN_IN(run), .ALARM_EN_IN(alarm_en),
    .AUTO_RST_WR_IN(ar_wr), .AUTO_RST_DATA_IN(ar_data),
    .CAPTURE_WR_IN(cap_wr), .CAPTURE_BE_IN(cap_be),
    .CAPTURE_DATA_IN(cap_data), .ALARM_WR_IN(alm_wr), .ALARM_BE_IN(alm_be),
    .ALARM_DATA_IN(alm_data), .LOAD_REQ_IN(load_req),
    .SNAP_REQ_IN(snap_req), .ALARM_IRQ_EN_IN(a_irq),
    .ALARM_WAKE_EN_IN(a_wake), .ALARM_RST_EN_IN(a_rst),
    .MCD_IRQ_EN_IN(m_irq), .MCD_WAKE_EN_IN(m_wake), .MCD_RST_EN_IN(m_rst),
    .TIMER_OUT(timer), .CAPTURE_OUT(capture), .ALARM_MATCH_OUT(match),
    .LOAD_BUSY_OUT(load_busy), .SNAP_BUSY_OUT(snap_busy),
    .AUTO_RST_OUT(auto_rst), .ALARM_FLAG_OUT(flag), .OSC_FAIL_OUT(fail),
    .CRYSTAL_VALID_OUT(valid), .IRQ_REQ_OUT(irq), .WAKE_REQ_OUT(wake),
    .RESET_REQ_OUT(rreq));

  // ****************************************************************
  // clock, oscillator, pulse counters
  // ****************************************************************
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cnt <= (cnt == 3) ? 0 : cnt + 1;
    if (osc_on && cnt == 3) osc <= #1 ~osc;
    if (irq === 1'b1) n_irq++;
    if (wake === 1'b1) n_wake++;
    if (rreq === 1'b1) n_rst++;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  // lane write: sel 0 capture, 1 match
  task automatic wr(input logic sel, input logic [3:0] be,
                    input logic [31:0] d);
    if (sel) begin
      alm_wr = 1;
      alm_be = be;
      alm_data = d;
    end else begin
      cap_wr = 1;
      cap_be = be;
      cap_data = d;
    end
    cyc(1);
    alm_wr = 0;
    cap_wr = 0;
    cyc(1);
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    while ((load_busy !== 1'b0 || snap_busy !== 1'b0) && i < 40) begin
      cyc(1);
      i++;
    end
    if (i >= 40) begin
      n_fail++;
      $display("[ERR] %0t busy stuck", $time);
    end
  endtask
  task automatic load(input logic [31:0] d);
    wr(0, 4'h3, {16'hDEAD, d[15:0]});
    wr(0, 4'hC, {d[31:16], 16'hBEEF});
    load_req = 1;
    cyc(1);
    chk_bit(load_busy, 1'b1, "load pending");
    load_req = 0;
    wait_idle();
  endtask
  task automatic snap;
    snap_req = 1;
    cyc(1);
    chk_bit(snap_busy, 1'b1, "snapshot pending");
    snap_req = 0;
    wait_idle();
  endtask
  task automatic next_tick(output logic [31:0] t);
    logic [31:0] old;
    int          i;
    old = timer;
    i = 0;
    while (timer === old && i < 20) begin
      cyc(1);
      i++;
    end
    if (i >= 20) begin
      n_fail++;
      $display("[ERR] %0t no tick", $time);
    end
    t = timer;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    sys_clk = 0;
    rst = 1;
    osc = 0;
    osc_en = 0;
    amp = 1;
    mcd_en = 0;
    fail_clr = 0;
    run = 0;
    alarm_en = 0;
    ar_wr = 0;
    ar_data = 0;
    cap_wr = 0;
    alm_wr = 0;
    load_req = 0;
    snap_req = 0;
    cap_be = 0;
    alm_be = 0;
    cap_data = 0;
    alm_data = 0;
    a_irq = 1;
    a_wake = 1;
    a_rst = 1;
    m_irq = 1;
    m_wake = 0;
    m_rst = 0;
    osc_on = 1;
    cnt = 0;
    n_fail = 0;
    comparisons = 0;
    n_irq = 0;
    n_wake = 0;
    n_rst = 0;
    repeat (12) @(posedge sys_clk);
    #1 rst = 0;
    cyc(40);
    chk(timer, 32'h0000_0000, "stopped timer");
    load(32'h1234_5678);
    chk(timer, 32'h1234_5678, "load");
    cyc(40);
    chk(timer, 32'h1234_5678, "held");
    snap();
    chk(capture, 32'h1234_5678, "snapshot");
    $display("test load_snapshot done");
    run = 1;
    load(32'hFFFF_FFFE);
    chk(timer, 32'hFFFF_FFFE, "load running");
    next_tick(v);
    chk(v, 32'hFFFF_FFFF, "increment");
    next_tick(v);
    chk(v, 32'h0000_0000, "wrap");
    snap();
    chk(capture, 32'h0000_0000, "snapshot running");
    chk(timer, 32'h0000_0001, "timer after snapshot");
    $display("test run_wrap done");
    wr(1, 4'h3, 32'hAAAA_0100);
    wr(1, 4'hC, 32'h0000_5555);
    chk(match, 32'h0000_0100, "match lanes");
    alarm_en = 1;
    load(32'h0000_00FE);
    n_irq = 0;
    n_wake = 0;
    n_rst = 0;
    next_tick(v);
    chk_bit(flag, 1'b0, "early flag");
    next_tick(v);
    chk_bit(flag, 1'b1, "alarm flag");
    next_tick(v);
    chk_bit(flag, 1'b0, "flag removed");
    chk(v, 32'h0000_0101, "no auto-reset");
    chk(n_irq + n_wake + n_rst, 3, "alarm pulses");
    $display("test alarm done");
    alarm_en = 0;
    a_wake = 0;
    a_rst = 0;
    ar_wr = 1;
    ar_data = 1;
    cyc(1);
    ar_wr = 0;
    chk_bit(auto_rst, 1'b1, "auto-reset on");
    wr(1, 4'hF, 32'h0000_0200); // period 0x201
    alarm_en = 1;
    load(32'h0000_01FF);
    n_irq = 0;
    n_wake = 0;
    n_rst = 0;
    next_tick(v);
    chk_bit(flag, 1'b1, "auto flag");
    next_tick(v);
    chk(v, 32'h0000_0000, "auto clear");
    chk(n_irq, 1, "irq gated");
    chk(n_wake + n_rst, 0, "wake reset gated");
    ar_wr = 1;
    ar_data = 0;
    cyc(1);
    ar_wr = 0;
    load(32'h0000_01FF);
    next_tick(v);
    chk_bit(flag, 1'b1, "flag before disable");
    alarm_en = 0;
    cyc(1);
    chk_bit(flag, 1'b0, "flag cleared by disable");
    $display("test auto_reset done");
    // perpetual timebase: match advanced by wrapping addition
    wr(1, 4'hF, 32'hFFFF_FFFE);
    alarm_en = 1;
    load(32'hFFFF_FFFC);
    next_tick(v);
    next_tick(v);
    chk_bit(flag, 1'b1, "perpetual alarm");
    alarm_en = 0;
    wr(1, 4'hF, 32'hFFFF_FFFE + 32'h0000_0003);
    alarm_en = 1;
    next_tick(v);
    next_tick(v);
    next_tick(v);
    chk(v, 32'h0000_0001, "timer past wrap");
    chk_bit(flag, 1'b1, "alarm after match wrap");
    // fixed interval: match set once, alarms counted
    alarm_en = 0;
    ar_wr = 1;
    ar_data = 1;
    cyc(1);
    ar_wr = 0;
    load(32'h0000_0000);
    wr(1, 4'hF, 32'h0000_0003); // period of four
    n_irq = 0;
    alarm_en = 1;
    cyc(96);
    chk(n_irq, 3, "fixed-interval alarms");
    chk(timer, 32'h0000_0000, "cleared each period");
    alarm_en = 0;
    $display("test timebase_modes done");
    mcd_en = 1;
    m_wake = 1;
    m_rst = 1;
    n_irq = 0;
    n_wake = 0;
    n_rst = 0;
    cyc(100);
    chk_bit(fail, 1'b0, "no false fail");
    osc_on = 0;
    cyc(35);
    chk_bit(fail, 1'b1, "stall detected");
    chk(n_irq, 1, "fail irq");
    chk(n_wake + n_rst, 2, "fail wake reset");
    osc_on = 1;
    cyc(40);
    chk_bit(fail, 1'b1, "fail sticky");
    fail_clr = 1;
    cyc(1);
    fail_clr = 0;
    cyc(1);
    chk_bit(fail, 1'b0, "fail cleared");
    mcd_en = 0; // off across the oscillator changes
    osc_on = 0;
    cyc(60);
    chk_bit(fail, 1'b0, "monitor off");
    osc_on = 1;
    $display("test missing_clock done");
    osc_en = 1;
    cyc(10);
    chk_bit(valid, 1'b0, "blanked");
    cyc(12);
    chk_bit(valid, 1'b1, "valid");
    amp = 0;
    cyc(3);
    chk_bit(valid, 1'b0, "amp low");
    mcd_en = 1; // back on once the oscillator is set
    cyc(40);
    chk_bit(fail, 1'b0, "monitor back on");
    $display("test crystal_valid done");
    end_sim();
  end

  initial begin
    #50000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule // rtc_core_test
